// ===== core/io_alarm_alert_monitor.sv
// alarm monitor: four inputs, supply limits, alert latch, wishbone slave
`include "alarm_mon_consts.svh"
`timescale 1ns/10ps
module io_alarm_alert_monitor #(
  parameter int TICK_CYCLES = `TICK_TIME_US * `CLK_FREQ_MHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // monitored lines
  input wire logic [3:0] din_i,
  input wire logic [7:0] supply_i,
  input wire logic rf_link_lost_i,
  // alarm message transmitter
  output logic msg_valid_o,
  input wire logic msg_ready_i,
  output logic [2:0] msg_src_o,
  output logic msg_raise_o,
  // alert pin
  output logic alert_o
);
  // ------------------------------------------------------------
  // tick divider
  // ------------------------------------------------------------
  logic [31:0] div_ff;
  logic tick_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == 32'(TICK_CYCLES - 1));
      div_ff <= (div_ff == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 :
                div_ff + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] rdat;
  logic [31:0] cfg_ff;
  logic [31:0] alert_cfg_ff;
  logic [31:0] supply_cfg_ff;
  logic [31:0] pcfg_ff [4];
  logic [3:0] port_alarm;
  logic [15:0] port_count [4];
  logic [5:0] raise_v;
  logic [5:0] clear_v;
  logic sup_lo_alarm;
  logic sup_hi_alarm;
  logic [5:0] pend_ff;
  logic [5:0] kind_ff;
  logic alert_ff;

  wire req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wr = req && wb_we_i;
  wire rd = req && !wb_we_i;
  wire [1:0] idx = wb_adr_i[3:2];
  wire hit_cfg = (wb_adr_i == `ADDR_CFG);
  wire hit_alert = (wb_adr_i == `ADDR_ALERT);
  wire hit_supply = (wb_adr_i == `ADDR_SUPPLY);
  wire hit_status = (wb_adr_i == `ADDR_STATUS);
  wire hit_pcfg = (wb_adr_i[7:4] == `PCFG_PAGE) && (wb_adr_i[1:0] == 2'h0);
  wire hit_pcnt = (wb_adr_i[7:4] == `PCNT_PAGE) && (wb_adr_i[1:0] == 2'h0);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // mode and configuration
  // ------------------------------------------------------------
  wire alarm_mon_pkg::mode_t mode = alarm_mon_pkg::mode_t'(cfg_ff[`CFG_MODE]);
  wire alarm_mon_pkg::alert_sel_t alert_sel =
    alarm_mon_pkg::alert_sel_t'(cfg_ff[`CFG_ALERT_SEL]);
  wire tx_en = cfg_ff[`CFG_TX_EN];
  wire hk_allowed = (mode != alarm_mon_pkg::MODE_EXT_BASE);
  // pulse counting only in extended mode
  wire ext_mode = (mode == alarm_mon_pkg::MODE_EXT_OUT) ||
                  (mode == alarm_mon_pkg::MODE_EXT_BASE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= `CFG_RST;
      alert_cfg_ff <= `ALERT_RST;
      supply_cfg_ff <= `SUPPLY_RST;
    end else if (wr) begin
      if (hit_cfg) begin
        cfg_ff <= merge(cfg_ff, wb_dat_i, wb_sel_i) & 32'h0000_001F;
      end else if (hit_alert) begin
        alert_cfg_ff <= merge(alert_cfg_ff, wb_dat_i, wb_sel_i) &
                        32'h0000_FFFF;
      end else if (hit_supply) begin
        supply_cfg_ff <= merge(supply_cfg_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ------------------------------------------------------------
  // digital input ports
  // ------------------------------------------------------------
  port_link_if plink [4] ();

  for (genvar p = 0; p < 4; p++) begin : g_port
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pcfg_ff[p] <= `PCFG_RST;
      end else if (wr && hit_pcfg && idx == 2'(p)) begin
        pcfg_ff[p] <= merge(pcfg_ff[p], wb_dat_i, wb_sel_i) &
                      32'hFF03_FFFF;
      end
    end

    assign plink[p].trip = pcfg_ff[p][`PCFG_TRIP];
    assign plink[p].rise_sel = pcfg_ff[p][`PCFG_RISE];
    assign plink[p].pulse_mode = pcfg_ff[p][`PCFG_PULSE] && ext_mode;
    assign plink[p].width = pcfg_ff[p][`PCFG_WIDTH];
    assign plink[p].cnt_clr = rd && hit_pcnt && idx == 2'(p);
    assign port_alarm[p] = plink[p].alarm;
    assign port_count[p] = plink[p].count;
    assign raise_v[p] = plink[p].raise_ev;
    assign clear_v[p] = plink[p].clear_ev;

    port_qual u_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_ff),
      .din_i(din_i[p]),
      .pif(plink[p])
    );
  end

  // ------------------------------------------------------------
  // supply limits
  // ------------------------------------------------------------
  // zero limit disables check
  wire lo_en = hk_allowed && (supply_cfg_ff[`SUP_LO_LIM] != 8'h00);
  wire hi_en = hk_allowed && (supply_cfg_ff[`SUP_HI_LIM] != 8'h00);
  wire lo_cond = supply_i < supply_cfg_ff[`SUP_LO_LIM];
  wire hi_cond = supply_i > supply_cfg_ff[`SUP_HI_LIM];

  dwell_qual u_sup_lo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_ff),
    .en_i(lo_en),
    .cond_i(lo_cond),
    .dwell_i(supply_cfg_ff[`SUP_LO_DWELL]),
    .alarm_o(sup_lo_alarm),
    .raise_o(raise_v[4]),
    .clear_o(clear_v[4])
  );

  dwell_qual u_sup_hi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_ff),
    .en_i(hi_en),
    .cond_i(hi_cond),
    .dwell_i(supply_cfg_ff[`SUP_HI_DWELL]),
    .alarm_o(sup_hi_alarm),
    .raise_o(raise_v[5]),
    .clear_o(clear_v[5])
  );

  // ------------------------------------------------------------
  // alert latch
  // ------------------------------------------------------------
  logic [15:0] alert_cnt_ff;
  logic src_ff;
  logic [15:0] nxt_alert_cnt;
  wire hk_alarm = rf_link_lost_i || sup_lo_alarm || sup_hi_alarm;
  wire io_alarm = |port_alarm;
  wire use_hk = (alert_sel == alarm_mon_pkg::ALERT_HK) ||
                (alert_sel == alarm_mon_pkg::ALERT_BOTH);
  wire use_io = (alert_sel == alarm_mon_pkg::ALERT_IO) ||
                (alert_sel == alarm_mon_pkg::ALERT_BOTH);
  wire alert_src = hk_allowed &&
                   ((use_hk && hk_alarm) || (use_io && io_alarm));

  always_comb begin
    nxt_alert_cnt = alert_cnt_ff;
    if (!hk_allowed) begin
      nxt_alert_cnt = 16'h0000;
    end else if (alert_src && !src_ff) begin
      nxt_alert_cnt = alert_cfg_ff[15:0];
    end else if (tick_ff && alert_cnt_ff != 16'h0000) begin
      nxt_alert_cnt = alert_cnt_ff - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_cnt_ff <= 16'h0000;
      src_ff <= 1'b0;
      alert_ff <= 1'b0;
    end else begin
      alert_cnt_ff <= nxt_alert_cnt;
      src_ff <= alert_src;
      alert_ff <= (nxt_alert_cnt != 16'h0000);
    end
  end

  assign alert_o = alert_ff;

  // ------------------------------------------------------------
  // alarm messages
  // ------------------------------------------------------------
  logic out_valid_ff;
  logic [2:0] out_src_ff;
  logic out_raise_ff;
  logic [5:0] nxt_pend;
  logic [5:0] nxt_kind;
  logic [5:0] take;
  logic [2:0] take_src;

  wire load = !out_valid_ff || msg_ready_i;
  wire [5:0] ev = (raise_v | clear_v) & {6{tx_en}};

  // lowest pending source goes first; a new event beats its own take
  always_comb begin
    take = 6'h00;
    take_src = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (pend_ff[i]) begin
        take = 6'h01 << i;
        take_src = 3'(i);
      end
    end
    if (!load) begin
      take = 6'h00;
    end
    nxt_pend = (pend_ff & ~take) | ev;
    nxt_kind = (kind_ff & ~ev) | (raise_v & ev);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= 6'h00;
      kind_ff <= 6'h00;
      out_valid_ff <= 1'b0;
      out_src_ff <= 3'h0;
      out_raise_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      kind_ff <= nxt_kind;
      if (load) begin
        out_valid_ff <= |pend_ff;
        out_src_ff <= take_src;
        out_raise_ff <= |(kind_ff & take);
      end
    end
  end

  assign msg_valid_o = out_valid_ff;
  assign msg_src_o = out_src_ff;
  assign msg_raise_o = out_raise_ff;

  // ------------------------------------------------------------
  // read data and acknowledge
  // ------------------------------------------------------------
  always_comb begin
    rdat = 32'h0000_0000;
    if (hit_cfg) begin
      rdat = cfg_ff;
    end else if (hit_alert) begin
      rdat = alert_cfg_ff;
    end else if (hit_supply) begin
      rdat = supply_cfg_ff;
    end else if (hit_status) begin
      rdat = {23'h000000, |pend_ff, rf_link_lost_i, alert_ff,
              sup_hi_alarm, sup_lo_alarm, port_alarm};
    end else if (hit_pcfg) begin
      rdat = pcfg_ff[idx];
    end else if (hit_pcnt) begin
      rdat = {16'h0000, port_count[idx]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (rd) begin
        rdat_ff <= rdat;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
endmodule

// ===== include/alarm_mon_consts.svh
// register map, field positions, reset values and timing constants
`ifndef ALARM_MON_CONSTS_SVH
`define ALARM_MON_CONSTS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ADDR_CFG 8'h00
`define ADDR_ALERT 8'h04
`define ADDR_SUPPLY 8'h08
`define ADDR_STATUS 8'h0C
`define PCFG_PAGE 4'h1
`define PCNT_PAGE 4'h2

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CFG_MODE 1:0
`define CFG_ALERT_SEL 3:2
`define CFG_TX_EN 4
`define PCFG_TRIP 15:0
`define PCFG_RISE 16
`define PCFG_PULSE 17
`define PCFG_WIDTH 31:24
`define SUP_LO_LIM 7:0
`define SUP_HI_LIM 15:8
`define SUP_LO_DWELL 23:16
`define SUP_HI_DWELL 31:24

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CFG_RST 32'h0000_0000
`define ALERT_RST 32'h0000_0000
`define SUPPLY_RST 32'h0101_0000
`define PCFG_RST 32'h0100_0000

// ------------------------------------------------------------
// timing and supply message source codes
// ------------------------------------------------------------
`define TICK_TIME_US 10000
`define CLK_FREQ_MHZ 125
`define SRC_LOW 3'h4
`define SRC_HIGH 3'h5

`endif

// ===== include/alarm_mon_pkg.sv
// types shared by the alarm monitor modules
package alarm_mon_pkg;

  typedef enum logic [1:0] {
    MODE_SPONT_BASE,
    MODE_SPONT_OUT,
    MODE_EXT_OUT,
    MODE_EXT_BASE
  } mode_t;

  typedef enum logic [1:0] {
    ALERT_OFF,
    ALERT_HK,
    ALERT_IO,
    ALERT_BOTH
  } alert_sel_t;

endpackage

// ===== include/port_link_if.sv
// configuration and status carried between the monitor and one port
`timescale 1ns/10ps
interface port_link_if;
  logic [15:0] trip;
  logic rise_sel;
  logic pulse_mode;
  logic [7:0] width;
  logic cnt_clr;
  logic alarm;
  logic [15:0] count;
  logic raise_ev;
  logic clear_ev;

  modport ctrl (
    output trip, rise_sel, pulse_mode, width, cnt_clr,
    input alarm, count, raise_ev, clear_ev
  );
  modport qual (
    input trip, rise_sel, pulse_mode, width, cnt_clr,
    output alarm, count, raise_ev, clear_ev
  );
endinterface

// ===== core/dwell_qual.sv
// dwell-time qualifier for one supply limit
`timescale 1ns/10ps
module dwell_qual (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  // condition
  input wire logic en_i,
  input wire logic cond_i,
  input wire logic [7:0] dwell_i,
  // result
  output logic alarm_o,
  output logic raise_o,
  output logic clear_o
);
  logic alarm_ff;
  logic [8:0] tmr_ff;
  logic [8:0] nxt_tmr;
  wire change = en_i && (cond_i != alarm_ff);
  wire done = change && (tmr_ff > {1'b0, dwell_i});

  always_comb begin
    nxt_tmr = tmr_ff;
    if (!change || done) begin
      nxt_tmr = 9'h000;
    end else if (tick_i && tmr_ff != 9'h1FF) begin
      nxt_tmr = tmr_ff + 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      alarm_ff <= 1'b0;
    end else if (done) begin
      alarm_ff <= ~alarm_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_ff <= 9'h000;
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign alarm_o = alarm_ff;
  assign raise_o = done && !alarm_ff;
  assign clear_o = done && alarm_ff;
endmodule

// ===== core/port_qual.sv
// one digital input: level alarm with dwell, or pulse counter
`timescale 1ns/10ps
module port_qual (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  // input line
  input wire logic din_i,
  // monitor side
  port_link_if.qual pif
);
  logic lvl_alarm_ff;
  logic [8:0] tmr_ff;
  logic [8:0] nxt_tmr;
  logic act_ff;
  logic [8:0] wcnt_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic pul_alarm_ff;

  wire active = pif.rise_sel ? din_i : ~din_i;
  wire armed = (pif.trip != 16'h0000);
  wire level = !pif.pulse_mode;
  wire change = level && armed && (active != lvl_alarm_ff);
  wire done = change && (tmr_ff > {1'b0, pif.width});

  always_comb begin
    nxt_tmr = tmr_ff;
    if (!change || done) begin
      nxt_tmr = 9'h000;
    end else if (tick_i && tmr_ff != 9'h1FF) begin
      nxt_tmr = tmr_ff + 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !level || !armed) begin
      lvl_alarm_ff <= 1'b0;
    end else if (done) begin
      lvl_alarm_ff <= ~lvl_alarm_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_ff <= 9'h000;
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  wire accept = pif.pulse_mode && act_ff && !active &&
                (wcnt_ff >= {1'b0, pif.width});

  always_comb begin
    nxt_cnt = cnt_ff;
    if (pif.cnt_clr) begin
      nxt_cnt = accept ? 16'h0001 : 16'h0000;
    end else if (accept && cnt_ff != 16'hFFFF) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_ff <= 1'b0;
      wcnt_ff <= 9'h000;
      cnt_ff <= 16'h0000;
    end else begin
      act_ff <= active;
      cnt_ff <= nxt_cnt;
      if (!active) begin
        wcnt_ff <= 9'h000;
      end else if (tick_i && wcnt_ff != 9'h1FF) begin
        wcnt_ff <= wcnt_ff + 9'h001;
      end
    end
  end

  wire pul_alarm = pif.pulse_mode && armed && (cnt_ff >= pif.trip);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pul_alarm_ff <= 1'b0;
    end else begin
      pul_alarm_ff <= pul_alarm;
    end
  end

  assign pif.alarm = level ? lvl_alarm_ff : pul_alarm;
  assign pif.count = cnt_ff;
  assign pif.raise_ev = (done && !lvl_alarm_ff) ||
                        (pul_alarm && !pul_alarm_ff);
  assign pif.clear_ev = done && lvl_alarm_ff;
endmodule

// ===== tb/io_alarm_chk.sv
// port-level assertions for the alarm monitor
`timescale 1ns/10ps
module io_alarm_chk #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // lines, messages, alert
  input wire logic [3:0] din_i,
  input wire logic [7:0] supply_i,
  input wire logic rf_link_lost_i,
  input wire logic msg_valid_o,
  input wire logic msg_ready_i,
  input wire logic [2:0] msg_src_o,
  input wire logic msg_raise_o,
  input wire logic alert_o
);
  // ----------------------------------------------------------
  // shadow of the settings written over the bus
  // ----------------------------------------------------------
  logic [1:0] mode_ff;
  logic tx_ever_ff;
  logic [15:0] ontime_ff;
  wire wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire wr_cfg = wr_take && wb_adr_i == 8'h00 && wb_sel_i[0];
  wire wr_alert = wr_take && wb_adr_i == 8'h04;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= 2'h0;
      tx_ever_ff <= 1'b0;
      ontime_ff <= 16'h0000;
    end else begin
      if (wr_cfg) mode_ff <= wb_dat_i[1:0];
      if (wr_cfg && wb_dat_i[4]) tx_ever_ff <= 1'b1;
      if (wr_alert && wb_sel_i[0]) ontime_ff[7:0] <= wb_dat_i[7:0];
      if (wr_alert && wb_sel_i[1]) ontime_ff[15:8] <= wb_dat_i[15:8];
    end
  end
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  a_reset_quiet: assert property (@(posedge clk_i)
    rst_i |=> !wb_ack_o && !msg_valid_o && !alert_o)
    else $error("outputs not quiet after reset");
  a_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i >= 8'h30 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C |-> wb_dat_o[31:9] == 23'h0)
    else $error("status reserved bits set");
  a_msg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_src_o)
    && $stable(msg_raise_o)) else $error("message changed before accept");
  a_msg_src: assert property (@(posedge clk_i) disable iff (rst_i)
    msg_valid_o |-> msg_src_o <= 3'h5) else $error("bad message source");
  a_tx_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(msg_valid_o) |-> tx_ever_ff)
    else $error("message sent with transmit never enabled");
  a_mode_no_alert: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_ff == 2'h3 && $past(mode_ff) == 2'h3 |-> !alert_o)
    else $error("alert on in extended base mode");
  a_zero_ontime: assert property (@(posedge clk_i) disable iff (rst_i)
    ontime_ff == 16'h0 && $past(ontime_ff) == 16'h0 |-> !$rose(alert_o))
    else $error("alert pulse with zero on-time");
endmodule
bind io_alarm_alert_monitor io_alarm_chk #(.TICK_CYCLES(TICK_CYCLES))
  io_alarm_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .din_i(din_i), .supply_i(supply_i),
  .rf_link_lost_i(rf_link_lost_i), .msg_valid_o(msg_valid_o),
  .msg_ready_i(msg_ready_i), .msg_src_o(msg_src_o),
  .msg_raise_o(msg_raise_o), .alert_o(alert_o));

// ===== tb/alarm_link_model.sv
// far side: input lines, supply level and alarm message receiver
`timescale 1ns/10ps
module alarm_link_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // lines toward the monitor
  output logic [3:0] din_o,
  output logic [7:0] supply_o,
  output logic rf_lost_o,
  // alarm messages
  input wire logic msg_valid_i,
  output logic msg_ready_o,
  input wire logic [2:0] msg_src_i,
  input wire logic msg_raise_i
);
  logic [3:0] q[$];
  int stall = 0;
  int wait_n = 0;
  initial begin
    din_o = 4'h0;
    supply_o = 8'h64;
    rf_lost_o = 1'b0;
    msg_ready_o = 1'b0;
  end
  task automatic lines(input logic [3:0] d, input logic [7:0] s,
                       input logic r);
    din_o <= d;
    supply_o <= s;
    rf_lost_o <= r;
  endtask
  // a slow receiver holds ready low for stall + 1 cycles per message
  always @(posedge clk_i) begin
    if (rst_i) begin
      msg_ready_o <= 1'b0;
      wait_n <= 0;
    end else if (msg_valid_i && msg_ready_o) begin
      q.push_back({msg_src_i, msg_raise_i});
      msg_ready_o <= 1'b0;
      wait_n <= 0;
    end else if (msg_valid_i) begin
      wait_n <= wait_n + 1;
      msg_ready_o <= (wait_n >= stall);
    end
  end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the alarm monitor
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] r;
  logic ack, rf, mv, mr, mraise, alert;
  logic [3:0] din;
  logic [7:0] sup;
  logic [2:0] ms;
  int fails = 0;
  int n_compared = 0;
  int cyc_n = 0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C,
                         8'h20, 8'h40};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0101_0000, 32'h0,
                          32'h0100_0000, 32'h0100_0000, 32'h0, 32'h0};
  always #4 clk_i = ~clk_i;
  io_alarm_alert_monitor #(.TICK_CYCLES(10)) io_alarm_alert_monitor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .din_i(din), .supply_i(sup),
    .rf_link_lost_i(rf), .msg_valid_o(mv), .msg_ready_i(mr),
    .msg_src_o(ms), .msg_raise_o(mraise), .alert_o(alert));
  alarm_link_model alarm_link_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .din_o(din), .supply_o(sup), .rf_lost_o(rf), .msg_valid_i(mv),
    .msg_ready_o(mr), .msg_src_i(ms), .msg_raise_i(mraise));
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wbx(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) fails++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbx(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    wbx(1'b0, a, 32'h0, 4'hF);
    chk(nm, r, e);
  endtask
  // waits for the next received message, {source, raise}
  task automatic msg(input logic [3:0] e);
    int n;
    logic [3:0] g;
    n = 0;
    while (alarm_link_model_inst.q.size() == 0 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    g = 4'hF;
    if (alarm_link_model_inst.q.size() != 0)
      g = alarm_link_model_inst.q.pop_front();
    chk("message", {28'h0, g}, {28'h0, e});
  endtask
  task automatic none();
    chk("queue", alarm_link_model_inst.q.size(), 32'h0);
  endtask
  task automatic lines(input logic [3:0] d, input logic [7:0] s,
                       input logic f, input int c);
    alarm_link_model_inst.lines(d, s, f);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // ------------------------------------------------------
    // reset values, byte lanes, refused writes
    // ------------------------------------------------------
    foreach (ra[i]) rd(ra[i], rv[i], "reset value");
    wbx(1'b1, 8'h04, 32'hFFFF_FFFF, 4'h1);
    rd(8'h04, 32'h0000_00FF, "alert lane");
    wr(8'h0C, 32'hFFFF_FFFF);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0, "status write");
    rd(8'h40, 32'h0, "unmapped");
    $display("test registers done");
    // ------------------------------------------------------
    // level inputs with dwell, alert latch
    // ------------------------------------------------------
    wr(8'h00, 32'h0000_001A);
    wr(8'h04, 32'h0000_0005);
    wr(8'h14, 32'h0301_0001);
    wr(8'h18, 32'h0301_0000);
    lines(4'h6, 8'h64, 1'b0, 25);
    none();
    lines(4'h0, 8'h64, 1'b0, 5);
    lines(4'h6, 8'h64, 1'b0, 25);
    none();
    msg(4'h3);
    chk("alert on", alert, 1'b1);
    rd(8'h0C, 32'h0000_0042, "status");
    none();
    lines(4'h6, 8'h64, 1'b0, 20);
    chk("alert held", alert, 1'b1);
    lines(4'h0, 8'h64, 1'b0, 0);
    msg(4'h2);
    lines(4'h0, 8'h64, 1'b0, 30);
    chk("alert off", alert, 1'b0);
    $display("test level done");
    // ------------------------------------------------------
    // pulse counting on port 0, low pulses, width 2
    // ------------------------------------------------------
    // park the line idle first: a long low level left over from the
    // level test would otherwise end as one valid pulse
    lines(4'h1, 8'h64, 1'b0, 5);
    wr(8'h10, 32'h0202_0002);
    lines(4'h0, 8'h64, 1'b0, 5);
    lines(4'h1, 8'h64, 1'b0, 5);
    lines(4'h0, 8'h64, 1'b0, 35);
    lines(4'h1, 8'h64, 1'b0, 5);
    rd(8'h20, 32'h1, "count one");
    rd(8'h20, 32'h0, "count cleared");
    repeat (2) begin
      lines(4'h0, 8'h64, 1'b0, 35);
      lines(4'h1, 8'h64, 1'b0, 5);
    end
    msg(4'h1);
    rd(8'h10, 32'h0202_0002, "trip kept");
    rd(8'h20, 32'h2, "count two");
    rd(8'h20, 32'h0, "count read clear");
    $display("test pulse done");
    // ------------------------------------------------------
    // supply low limit, high limit off, slow receiver
    // ------------------------------------------------------
    alarm_link_model_inst.stall = 3;
    wr(8'h08, 32'h0002_0032);
    lines(4'h1, 8'h28, 1'b0, 15);
    none();
    msg(4'h9);
    lines(4'h1, 8'hFA, 1'b0, 0);
    msg(4'h8);
    lines(4'h1, 8'hFA, 1'b0, 60);
    none();
    $display("test supply done");
    // ------------------------------------------------------
    // housekeeping alert without messages, then ext base
    // ------------------------------------------------------
    alarm_link_model_inst.stall = 0;
    wr(8'h00, 32'h0000_0005);
    lines(4'h1, 8'h64, 1'b1, 3);
    chk("hk alert", alert, 1'b1);
    lines(4'h0, 8'h64, 1'b0, 60);
    none();
    chk("hk expired", alert, 1'b0);
    wr(8'h00, 32'h0000_0002);
    lines(4'h0, 8'h64, 1'b1, 5);
    chk("alert sel off", alert, 1'b0);
    wr(8'h00, 32'h0000_001F);
    lines(4'h0, 8'h28, 1'b0, 3);
    lines(4'h0, 8'h28, 1'b1, 60);
    chk("ext base alert", alert, 1'b0);
    none();
    $display("test modes done");
    summarize();
  end
endmodule
